//--- verilog/tmo_timer.sv
// Design decision made here: the plain strobed port.
`include "tmo_consts.svh"

module tmo_timer (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       capcomp_trigger,
  input  wire logic [3:0] capcomp_mode_code,
  input  wire logic [1:0] port_direction,
  input  wire logic [1:0] port_latch,
  input  wire logic       ext_clock_pin_i,
  output logic            ext_clock_pin_o,
  output logic            ext_clock_pin_oe,
  input  wire logic       crystal_in_pin_i,
  output logic            crystal_in_pin_o,
  output logic            crystal_in_pin_oe,
  output logic            crystal_osc_enable,
  output logic            irq
);
  import tmo_pkg::*;

  // ========================================================================
  // State and local signals
  // ========================================================================
  tmo_pkg::tmo_core_s  r;
  tmo_pkg::tmo_core_s  n;
  tmo_pkg::tmo_mode_e  mode;
  logic                count_on;
  logic                clock_source_select;
  logic                sync_bypass;
  logic                crystal_osc_on;
  logic [1:0]          prescale_sel;
  logic                inst_tick;
  logic                ext_rise;
  logic                src_tick;
  logic                ps_tick;
  logic                adv;
  logic                ccp_clear;
  logic                wr_lo;
  logic                wr_hi;
  logic                presc_clear;
  logic [15:0]         cnt;
  logic                ovf;
  logic                crystal_pin_unused;

  // The crystal input is analog in silicon; its logic level is not used here
  assign crystal_pin_unused = crystal_in_pin_i;

  // ========================================================================
  // Control field decode
  // ========================================================================
  assign count_on            = r.ctrl[`TMO_BIT_ON];
  assign clock_source_select = r.ctrl[`TMO_BIT_CS];
  assign sync_bypass         = r.ctrl[`TMO_BIT_SYNC];
  assign crystal_osc_on      = r.ctrl[`TMO_BIT_OSC];
  assign prescale_sel        = {r.ctrl[`TMO_BIT_PS_HI], r.ctrl[`TMO_BIT_PS_LO]};

  // Mode selection; the sync bit only matters with the pin as source
  always_comb begin
    if (!clock_source_select) begin
      mode = TMO_MODE_TIMER;
    end else if (sync_bypass) begin
      mode = TMO_MODE_ASYNC;
    end else begin
      mode = TMO_MODE_SYNC;
    end
  end

  // ========================================================================
  // Clock sources
  // ========================================================================
  // Instruction cycle is one core clock in four
  assign inst_tick = (r.phase == `TMO_PHASE_LAST);

  // Pin edges; the synchroniser adds two cycles of latency
  tmo_edge_sync u_edge (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pin_in  (ext_clock_pin_i),
    .rise    (ext_rise)
  );

  // Gated source ahead of the prescaler so a stopped timer holds the prescaler; a pending synchronous edge can still count once
  always_comb begin
    unique case (mode)
      TMO_MODE_TIMER: src_tick = inst_tick & count_on;
      TMO_MODE_SYNC:  src_tick = ext_rise & count_on;
      TMO_MODE_ASYNC: src_tick = ext_rise & count_on;
    endcase
  end

  // ========================================================================
  // Register strobes and count reset
  // ========================================================================
  assign wr_lo     = reg_wr & (reg_addr == `TMO_ADDR_LO);
  assign wr_hi     = reg_wr & (reg_addr == `TMO_ADDR_HI);
  assign ccp_clear = capcomp_trigger & (capcomp_mode_code == `TMO_CCP_SPECIAL);

  // A count write or trigger restarts the prescaler so the next period is whole
  assign presc_clear = wr_lo | wr_hi | ccp_clear;

  tmo_prescaler u_presc (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .tick_in  (src_tick),
    .clear    (presc_clear),
    .sel      (prescale_sel),
    .tick_out (ps_tick)
  );

  // ========================================================================
  // Advance decision
  // ========================================================================
  // Synchronous mode holds a prescaled edge until the next instruction cycle;
  // asynchronous mode skips that wait, trading alignment for latency
  always_comb begin
    unique case (mode)
      TMO_MODE_SYNC: adv = (r.pend | ps_tick) & inst_tick;
      TMO_MODE_ASYNC: adv = ps_tick;
      TMO_MODE_TIMER: adv = ps_tick;
    endcase
  end

  assign cnt = {r.cnt_hi, r.cnt_lo};
  assign ovf = adv & ~ccp_clear & (cnt == `TMO_CNT_MAX);

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    n       = r;
    n.phase = r.phase + 2'h1;

    // Pending edge only lives in synchronous mode
    if (mode == TMO_MODE_SYNC) begin
      n.pend = (r.pend | ps_tick) & ~inst_tick;
    end else begin
      n.pend = 1'b0;
    end

    // Count: trigger clear beats an increment, a byte write beats both
    if (ccp_clear) begin
      {n.cnt_hi, n.cnt_lo} = 16'h0000;
    end else if (adv) begin
      {n.cnt_hi, n.cnt_lo} = cnt + 16'h0001;
    end
    if (wr_lo) begin
      n.cnt_lo = reg_wdata;
    end
    if (wr_hi) begin
      n.cnt_hi = reg_wdata;
    end

    // Control: only the six implemented bits are stored
    if (reg_wr && (reg_addr == `TMO_ADDR_CTRL)) begin
      n.ctrl = reg_wdata[5:0];
    end

    // Mask register
    if (reg_wr && (reg_addr == `TMO_ADDR_MASK)) begin
      n.mask = reg_wdata[`TMO_BIT_OVF];
    end

    // Flag: a read clears it, but an overflow in the same cycle wins
    if (reg_rd && (reg_addr == `TMO_ADDR_FLAG)) begin
      n.flag = 1'b0;
    end
    if (ovf) begin
      n.flag = 1'b1;
    end

    // Level interrupt, aligned with the flag it reflects
    n.irq = n.flag & n.mask;

    // Read data stands only in the cycle after the read
    n.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `TMO_ADDR_LO:   n.rdata = r.cnt_lo;
        `TMO_ADDR_HI:   n.rdata = r.cnt_hi;
        `TMO_ADDR_CTRL: n.rdata = {2'b00, r.ctrl};
        `TMO_ADDR_FLAG: n.rdata = {7'h00, r.flag};
        `TMO_ADDR_MASK: n.rdata = {7'h00, r.mask};
        default:        n.rdata = 8'h00;
      endcase
    end

    // Oscillator enable follows its control bit
    n.osc_en = n.ctrl[`TMO_BIT_OSC];

    // Pins: running oscillator forces both to inputs, else the port drives
    n.pin_out = port_latch;
    n.pin_oe  = ~port_direction & {2{~crystal_osc_on}};
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r         <= '0;
      r.ctrl    <= `TMO_CTRL_RST;
      r.flag    <= `TMO_FLAG_RST;
      r.mask    <= `TMO_MASK_RST;
      r.cnt_lo  <= `TMO_CNT_RST;
      r.cnt_hi  <= `TMO_CNT_RST;
      r.pin_oe  <= 2'h0;
      r.pin_out <= 2'h0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  // ========================================================================
  assign reg_rdata          = r.rdata;
  assign irq                = r.irq;
  assign crystal_osc_enable = r.osc_en;
  assign ext_clock_pin_o    = r.pin_out[0];
  assign ext_clock_pin_oe   = r.pin_oe[0];
  assign crystal_in_pin_o   = r.pin_out[1];
  assign crystal_in_pin_oe  = r.pin_oe[1];

endmodule

//--- verilog/tmo_consts.svh
`ifndef TMO_CONSTS_SVH
`define TMO_CONSTS_SVH

// ==========================================================================
// Register offsets on the plain register port
// ==========================================================================
`define TMO_ADDR_FLAG   8'h0c
`define TMO_ADDR_LO     8'h0e
`define TMO_ADDR_HI     8'h0f
`define TMO_ADDR_CTRL   8'h10
`define TMO_ADDR_MASK   8'h8c

// ==========================================================================
// Control register field positions and reset value
// ==========================================================================
`define TMO_BIT_ON      0
`define TMO_BIT_CS      1
`define TMO_BIT_SYNC    2
`define TMO_BIT_OSC     3
`define TMO_BIT_PS_LO   4
`define TMO_BIT_PS_HI   5
`define TMO_CTRL_RST    6'h00

// ==========================================================================
// Flag and mask layout, reset values
// ==========================================================================
`define TMO_BIT_OVF     0
`define TMO_FLAG_RST    1'h0
`define TMO_MASK_RST    1'h0
`define TMO_CNT_RST     8'h00

// ==========================================================================
// Timing and encodings
// ==========================================================================
`define TMO_PHASE_LAST  2'h3
`define TMO_CNT_MAX     16'hffff
`define TMO_CCP_SPECIAL 4'hb

`endif

//--- verilog/tmo_pkg.sv
package tmo_pkg;

  // ========================================================================
  // Operating modes, one-hot
  // ========================================================================
  typedef enum logic [2:0] {
    TMO_MODE_TIMER = 3'b001,
    TMO_MODE_SYNC  = 3'b010,
    TMO_MODE_ASYNC = 3'b100
  } tmo_mode_e;

  // ========================================================================
  // State of each module
  // ========================================================================
  typedef struct packed {
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [5:0] ctrl;
    logic       flag;
    logic       mask;
    logic [1:0] phase;
    logic       pend;
    logic [7:0] rdata;
    logic       irq;
    logic [1:0] pin_oe;
    logic [1:0] pin_out;
    logic       osc_en;
  } tmo_core_s;

  typedef struct packed {
    logic [2:0] cnt;
  } tmo_presc_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } tmo_edge_s;

endpackage

//--- verilog/tmo_edge_sync.sv
module tmo_edge_sync (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      rise
);
  import tmo_pkg::*;

  tmo_pkg::tmo_edge_s r;
  tmo_pkg::tmo_edge_s n;

  // ========================================================================
  // Two-flop synchroniser, then edge detection on the second stage only
  // ========================================================================
  always_comb begin
    n       = r;
    n.sync1 = pin_in;
    n.sync2 = r.sync1;
    n.prev  = r.sync2;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  // Rising edge of the pin, one cycle wide
  assign rise = r.sync2 & ~r.prev;

endmodule

//--- verilog/tmo_prescaler.sv
`include "tmo_consts.svh"

module tmo_prescaler (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  output logic            tick_out
);
  import tmo_pkg::*;

  tmo_pkg::tmo_presc_s r;
  tmo_pkg::tmo_presc_s n;
  logic [2:0]          div_mask;

  // ========================================================================
  // Division mask: 1, 2, 4 or 8 input ticks per output tick
  // ========================================================================
  always_comb begin
    unique case (sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      2'h3:    div_mask = 3'h7;
    endcase
  end

  assign tick_out = tick_in & ((r.cnt & div_mask) == div_mask);

  // Clear wins so a count write restarts the division cleanly
  always_comb begin
    n = r;
    if (clear) begin
      n.cnt = 3'h0;
    end else if (tick_in) begin
      n.cnt = r.cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

endmodule

//--- verification/tmo_assertions.sv
`include "tmo_consts.svh"

module tmo_assertions (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_clock_pin_oe,
  input wire logic       crystal_in_pin_oe,
  input wire logic       crystal_osc_enable,
  input wire logic       irq
);
  // ==================
  // Accepted strobes
  // ==================
  wire wr_go = reg_wr & clk_en;
  wire rd_go = reg_rd & clk_en;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Write then immediate read of the same place
  sequence s_ctrl_wr_rd;
    wr_go && reg_addr == `TMO_ADDR_CTRL ##1 rd_go && reg_addr == `TMO_ADDR_CTRL;
  endsequence
  sequence s_hi_wr_rd;
    wr_go && reg_addr == `TMO_ADDR_HI ##1 rd_go && reg_addr == `TMO_ADDR_HI;
  endsequence
  // Control written once, then left alone for a cycle
  sequence s_ctrl_wr_once;
    wr_go && reg_addr == `TMO_ADDR_CTRL ##1 !(wr_go && reg_addr == `TMO_ADDR_CTRL);
  endsequence

  // ==================
  // Properties
  // ==================
  a_rdata_idle_zero: assert property (
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctrl_top_zero: assert property (
    rd_go && reg_addr == `TMO_ADDR_CTRL |=> reg_rdata[7:6] == 2'h0)
    else $error("control top bits read nonzero");
  a_ctrl_read_back: assert property (
    s_ctrl_wr_rd |=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
    else $error("control read back differs from write");
  a_high_read_back: assert property (s_hi_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("count high byte read back differs");
  // Enable changes at the same edge as the control write; the check waits out the quiet cycle, so looks two cycles on
  a_osc_follows_bit: assert property (
    s_ctrl_wr_once |-> ##1 crystal_osc_enable == $past(reg_wdata[3], 2))
    else $error("oscillator enable does not follow control bit 3");
  a_osc_frees_pins: assert property (
    crystal_osc_enable && $past(crystal_osc_enable) |-> !ext_clock_pin_oe && !crystal_in_pin_oe)
    else $error("crystal pins driven while oscillator runs");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> $past(rd_go && reg_addr == `TMO_ADDR_FLAG)
      || $past(wr_go && reg_addr == `TMO_ADDR_MASK)
      || $past(wr_go && reg_addr == `TMO_ADDR_MASK, 2))
    else $error("interrupt dropped without flag read or mask write");
  a_mask_drops_irq: assert property (
    wr_go && reg_addr == `TMO_ADDR_MASK && !reg_wdata[0] |-> ##[1:2] !irq)
    else $error("interrupt stays high after mask cleared");
  // A low enable must hold read data, interrupt and oscillator enable where they were
  a_freeze_holds: assert property (
    !clk_en |=> $stable(reg_rdata) && $stable(irq) && $stable(crystal_osc_enable))
    else $error("outputs moved while clock enable was low");
endmodule

bind tmo_timer tmo_assertions chk_u (
  .mclk               (mclk),
  .reset_n            (reset_n),
  .clk_en             (clk_en),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .ext_clock_pin_oe   (ext_clock_pin_oe),
  .crystal_in_pin_oe  (crystal_in_pin_oe),
  .crystal_osc_enable (crystal_osc_enable),
  .irq                (irq)
);

//--- verification/tmo_pin_src.sv
module tmo_pin_src (
  input  wire logic       go,
  input  wire logic [7:0] edges,
  input  wire logic [7:0] half,
  output logic            pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Burst of rising edges; the source stands low between bursts
  initial pin = 1'b0;
  // Small offset keeps the pin edges off the clock's sampling edge
  always @(posedge go) begin
    #3;
    repeat (edges) begin
      #(half) pin = 1'b1;
      #(half) pin = 1'b0;
    end
  end
endmodule

//--- verification/testbench.sv
`include "tmo_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk, reset_n, reg_wr, reg_rd, trig, go, irq, osc, pin, p0e, p1e;
  logic       ce, p0o, p1o;
  logic [7:0] reg_addr, reg_wdata, rdata, n_edges, half;
  logic [1:0] port_dir, latch;
  logic [3:0] mode;
  int         n_errors, total_checks;

  tmo_timer dut_u (
    .mclk(mclk), .reset_n(reset_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .capcomp_trigger(trig), .capcomp_mode_code(mode), .port_direction(port_dir),
    .port_latch(latch), .ext_clock_pin_i(pin), .ext_clock_pin_o(p0o), .ext_clock_pin_oe(p0e),
    .crystal_in_pin_i(1'b0), .crystal_in_pin_o(p1o), .crystal_in_pin_oe(p1e),
    .crystal_osc_enable(osc), .irq(irq)
  );

  tmo_pin_src src_u (.go(go), .edges(n_edges), .half(half), .pin(pin));

  // ==================
  // Bus tasks
  // ==================
  // Write strobe is left up so writes may follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask

  task automatic gap(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // Read data stands only in the cycle after the strobe, so sample there
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge mclk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==================
  // Scenarios
  // ==================
  task automatic t_reset();
    rdchk(`TMO_ADDR_CTRL, 8'h00);
    rdchk(`TMO_ADDR_LO, 8'h00);
    rdchk(`TMO_ADDR_HI, 8'h00);
    rdchk(`TMO_ADDR_FLAG, 8'h00);
    rdchk(8'h33, 8'h00);
    `CHK(osc, 1'b0)
  endtask

  // Outputs on pins, then oscillator on with top bits written as ones
  task automatic t_ctrl();
    port_dir <= 2'b00;
    latch    <= 2'b10;
    gap(2);
    `CHK({p0e, p1e}, 2'b11)
    `CHK({p0o, p1o}, 2'b01)
    wr(`TMO_ADDR_CTRL, 8'hf8);
    rdchk(`TMO_ADDR_CTRL, 8'h38);
    gap(1);
    `CHK({osc, p0e, p1e}, 3'b100)
    port_dir <= 2'b11;
    wr(`TMO_ADDR_CTRL, 8'h00);
  endtask

  // 64 core cycles hold 16 instruction ticks, divided by 1, 2, 4, 8; bit 2 set must not matter
  task automatic t_timer();
    for (int ps = 0; ps < 4; ps++) begin
      wr(`TMO_ADDR_CTRL, {2'h0, ps[1:0], 4'h5});
      wr(`TMO_ADDR_LO, 8'h00);
      gap(63);
      wr(`TMO_ADDR_CTRL, 8'h00);
      rdchk(`TMO_ADDR_LO, 8'd16 >> ps);
      gap(20);
      rdchk(`TMO_ADDR_LO, 8'd16 >> ps);
    end
  endtask

  // Same 64 enabled cycles with a 40-cycle freeze inside: the phase stops too
  task automatic t_freeze();
    wr(`TMO_ADDR_CTRL, 8'h01);
    wr(`TMO_ADDR_LO, 8'h00);
    gap(31);
    ce <= 1'b0;
    gap(40);
    ce <= 1'b1;
    gap(32);
    wr(`TMO_ADDR_CTRL, 8'h00);
    rdchk(`TMO_ADDR_LO, 8'd16);
  endtask

  task automatic t_ovf();
    wr(`TMO_ADDR_MASK, 8'h01);
    wr(`TMO_ADDR_HI, 8'hff);
    wr(`TMO_ADDR_LO, 8'hfe);
    wr(`TMO_ADDR_CTRL, 8'h01);
    gap(12);
    wr(`TMO_ADDR_CTRL, 8'h00);
    `CHK(irq, 1'b1)
    rdchk(`TMO_ADDR_HI, 8'h00);
    wr(`TMO_ADDR_MASK, 8'h00);
    gap(2);
    `CHK(irq, 1'b0)
    wr(`TMO_ADDR_MASK, 8'h01);
    rdchk(`TMO_ADDR_FLAG, 8'h01);
    rdchk(`TMO_ADDR_FLAG, 8'h00);
    `CHK(irq, 1'b0)
  endtask

  // A trigger clears the count only in the special-event mode
  task automatic t_trig();
    wr(`TMO_ADDR_HI, 8'h12);
    rdchk(`TMO_ADDR_HI, 8'h12);
    wr(`TMO_ADDR_LO, 8'h55);
    mode <= 4'h0;
    trig <= 1'b1;
    gap(1);
    trig <= 1'b0;
    rdchk(`TMO_ADDR_LO, 8'h55);
    mode <= `TMO_CCP_SPECIAL;
    trig <= 1'b1;
    gap(1);
    trig <= 1'b0;
    rdchk(`TMO_ADDR_LO, 8'h00);
    rdchk(`TMO_ADDR_HI, 8'h00);
  endtask

  // Pin counting: synchronous, asynchronous, then divided by two
  task automatic t_count();
    logic [7:0] cfg [3] = '{8'h03, 8'h07, 8'h17};
    logic [7:0] expv [3] = '{8'h05, 8'h05, 8'h02};
    for (int i = 0; i < 3; i++) begin
      wr(`TMO_ADDR_CTRL, cfg[i]);
      wr(`TMO_ADDR_LO, 8'h00);
      n_edges <= 8'd5;
      half <= 8'd60 + 8'(i * 40);
      go <= 1'b1;
      gap(90);
      go <= 1'b0;
      wr(`TMO_ADDR_CTRL, 8'h00);
      rdchk(`TMO_ADDR_LO, expv[i]);
    end
  endtask

  // ==================
  // Clock, watchdog, main sequence
  // ==================
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #200us;
    n_errors++;
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, trig, go} = 4'h0;
    {reg_addr, reg_wdata, n_edges, half} = 32'h0;
    port_dir = 2'b11;
    latch = 2'b00;
    ce = 1'b1;
    mode = 4'h0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_ctrl();
    t_timer();
    t_freeze();
    t_ovf();
    t_trig();
    t_count();
    report_and_stop();
  end
endmodule
